/* File: verilog/tefl_top.v */
// Counter, event detection and flags of a 16-bit timer with two channels.
// Contract
// - Free-running counter wraps 0xFFFF to zero.
// - Overflow flag set on free-run wrap.
// - Overflow flag set on modulus-to-zero step.
// - Up/down: overflow flag set at the reversal at modulus.
// - Up/down: zero count is period midpoint.
// - Edge select: rising, falling, either, none.
// - Capture channel flag set on selected edge.
// - Compare channel flag set on counter match.
// - Edge PWM flag set at duty match.
// - Center PWM matches twice per period.
// - Center PWM flag set at both matches.
// - Flags cleared only by two-step sequence.
// - Sequence: read flag as one, write zero.
// - Event between steps restarts sequence.
// - Enabled flag drives level interrupt request.
// - Center select chooses up/down counting.
`timescale 1ns/10ps
`default_nettype none
`include "tefl_defs.vh"
module tefl_top (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Counting control
   input wire count_en,
   input wire center_align_select,
   input wire [15:0] modulus,
   // Channel configuration, two channels packed
   input wire [3:0] chan_mode,
   input wire [3:0] edge_level_select,
   input wire [31:0] chan_value,
   input wire [1:0] chan_pin,
   // Interrupt enables
   input wire overflow_irq_enable,
   input wire [1:0] channel_irq_enable,
   // Software flag access
   input wire ovf_rd,
   input wire ovf_wr_zero,
   input wire [1:0] chan_rd,
   input wire [1:0] chan_wr_zero,
   // Status
   output reg [15:0] count_ff,
   output reg count_dir_ff,
   output reg overflow_flag,
   output reg [1:0] channel_event_flag,
   output reg overflow_irq_ff,
   output reg [1:0] channel_irq_ff
);
   reg [15:0] nxt_count;
   reg nxt_dir;
   reg ovf_evt;
   reg [1:0] pin_ff;
   reg [1:0] chan_evt;
   wire [15:0] limit;
   wire ovf_q;
   wire [1:0] chan_q;
   integer i;

   // Modulus zero means the full 16-bit range in up-counting mode.
   assign limit = (modulus == `TEFL_CNT_ZERO) ? `TEFL_CNT_MAX : modulus;

   // Edge decode used by every capture channel.
   function edge_hit;
      input [1:0] sel;
      input prev;
      input cur;
      begin
         case (sel)
            `TEFL_EDGE_RISE: edge_hit = ~prev & cur;
            `TEFL_EDGE_FALL: edge_hit = prev & ~cur;
            `TEFL_EDGE_ANY: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction

   // Next count and overflow event for both counting modes.
   always @* begin
      nxt_count = count_ff;
      nxt_dir = count_dir_ff;
      ovf_evt = 1'b0;
      if (count_en) begin
         if (!center_align_select) begin
            nxt_dir = `TEFL_DIR_UP;
            if (count_ff >= limit) begin
               nxt_count = `TEFL_CNT_ZERO;
               ovf_evt = 1'b1;
            end else begin
               nxt_count = count_ff + 16'h0001;
            end
         end else if (count_dir_ff == `TEFL_DIR_UP) begin
            if (count_ff >= modulus) begin
               // Reversal at the terminal count ends the period.
               nxt_dir = `TEFL_DIR_DOWN;
               nxt_count = count_ff - 16'h0001;
               ovf_evt = 1'b1;
            end else begin
               nxt_count = count_ff + 16'h0001;
            end
         end else begin
            // Zero is the middle of the period, so no flag here.
            if (count_ff == `TEFL_CNT_ZERO) begin
               nxt_dir = `TEFL_DIR_UP;
               nxt_count = count_ff + 16'h0001;
            end else begin
               nxt_count = count_ff - 16'h0001;
            end
         end
      end
   end

   // Channel events; a match is taken once per count value visited.
   always @* begin
      for (i = 0; i < 2; i = i + 1) begin
         case (chan_mode[2*i +: 2])
            `TEFL_MODE_CAPTURE:
               chan_evt[i] = edge_hit(edge_level_select[2*i +: 2],
                  pin_ff[i], chan_pin[i]);
            `TEFL_MODE_COMPARE, `TEFL_MODE_PWM:
               // In up/down mode the value is passed up and down.
               chan_evt[i] = count_en &&
                  (count_ff == chan_value[16*i +: 16]);
            default: chan_evt[i] = 1'b0;
         endcase
      end
   end

   // Counter, pin history and interrupt outputs.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= `TEFL_CNT_ZERO;
         count_dir_ff <= `TEFL_DIR_UP;
         pin_ff <= 2'h0;
         overflow_flag <= 1'b0;
         channel_event_flag <= 2'h0;
         overflow_irq_ff <= 1'b0;
         channel_irq_ff <= 2'h0;
      end else begin
         count_ff <= nxt_count;
         count_dir_ff <= nxt_dir;
         pin_ff <= chan_pin;
         overflow_flag <= ovf_q;
         channel_event_flag <= chan_q;
         // Level request follows the flag while enabled.
         overflow_irq_ff <= ovf_q & overflow_irq_enable;
         channel_irq_ff <= chan_q & channel_irq_enable;
      end
   end

   // Overflow flag.
   tefl_flag u_ovf (
      .clk(clk),
      .rst(rst),
      .event_in(ovf_evt),
      .rd_stb(ovf_rd),
      .wr_zero_stb(ovf_wr_zero),
      .flag_ff(ovf_q)
   );

   // Channel flags.
   tefl_flag u_ch0 (
      .clk(clk),
      .rst(rst),
      .event_in(chan_evt[0]),
      .rd_stb(chan_rd[0]),
      .wr_zero_stb(chan_wr_zero[0]),
      .flag_ff(chan_q[0])
   );
   tefl_flag u_ch1 (
      .clk(clk),
      .rst(rst),
      .event_in(chan_evt[1]),
      .rd_stb(chan_rd[1]),
      .wr_zero_stb(chan_wr_zero[1]),
      .flag_ff(chan_q[1])
   );
endmodule // tefl_top
`default_nettype wire

/* File: verilog/tefl_defs.vh */
// Constants for the timer event-flag logic.
`ifndef TEFL_DEFS_VH
`define TEFL_DEFS_VH
`define TEFL_CNT_W 16
`define TEFL_NCH 2
`define TEFL_CNT_MAX 16'hFFFF
`define TEFL_CNT_ZERO 16'h0000
`define TEFL_EDGE_OFF 2'h0
`define TEFL_EDGE_RISE 2'h1
`define TEFL_EDGE_FALL 2'h2
`define TEFL_EDGE_ANY 2'h3
`define TEFL_MODE_CAPTURE 2'h0
`define TEFL_MODE_COMPARE 2'h1
`define TEFL_MODE_PWM 2'h2
`define TEFL_DIR_UP 1'b0
`define TEFL_DIR_DOWN 1'b1
`endif

/* File: verilog/tefl_flag.v */
// One event flag with the read-then-write-zero clearing sequence.
`timescale 1ns/10ps
`default_nettype none
module tefl_flag (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Event and software access
   input wire event_in,
   input wire rd_stb,
   input wire wr_zero_stb,
   // Flag state
   output reg flag_ff
);
   reg armed_ff;
   reg nxt_flag;
   reg nxt_armed;

   // A read of a set flag arms the clear; a new event disarms it again.
   always @* begin
      nxt_flag = flag_ff;
      nxt_armed = armed_ff;
      if (rd_stb && flag_ff) begin
         nxt_armed = 1'b1;
      end
      if (wr_zero_stb && armed_ff) begin
         nxt_flag = 1'b0;
         nxt_armed = 1'b0;
      end
      if (event_in) begin
         nxt_flag = 1'b1; // Set wins over clear.
         nxt_armed = 1'b0;
      end
   end

   // Flag storage.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
         armed_ff <= nxt_armed;
      end
   end
endmodule // tefl_flag
`default_nettype wire

/* File: test/tefl_top_assertions.sv */
// Checker for the timer counter and its event flags.
`timescale 1ns/10ps
`default_nettype none
module tefl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Controls
   input wire logic count_en,
   input wire logic center_align_select,
   input wire logic [15:0] modulus,
   input wire logic [3:0] chan_mode,
   input wire logic [3:0] edge_level_select,
   input wire logic [31:0] chan_value,
   input wire logic [1:0] chan_pin,
   input wire logic overflow_irq_enable,
   input wire logic ovf_wr_zero,
   // Status
   input wire logic [15:0] count_ff,
   input wire logic count_dir_ff,
   input wire logic overflow_flag,
   input wire logic [1:0] channel_event_flag,
   input wire logic overflow_irq_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // A zero modulus stands for the full range in up counting.
   wire [15:0] lim = (modulus == 16'h0000) ? 16'hffff : modulus;
   wire up = !center_align_select;
   sequence s_top(m);
      count_en && m && !count_dir_ff && count_ff == lim;
   endsequence
   sequence s_turn;
      count_dir_ff ##1 overflow_flag;
   endsequence
   a_top_wrap: assert property (s_top(up) |=> !count_ff)
      else $error("counter missed its wrap");
   a_up_ovf: assert property (s_top(up) |-> ##2 overflow_flag)
      else $error("overflow flag missed");
   a_dir_turn: assert property (s_top(center_align_select) |=> s_turn)
      else $error("no turn at modulus");
   a_mid_turn: assert property (count_en && center_align_select &&
      count_dir_ff && !count_ff |=> !count_dir_ff)
      else $error("no turn at zero");
   a_chan_match: assert property (count_en && ^chan_mode[3:2] &&
      count_ff == chan_value[31:16] |-> ##2 channel_event_flag[1])
      else $error("match flag missed");
   a_cap_rise: assert property (!chan_mode[1:0] &&
      edge_level_select[1:0] == 2'h1 && $rose(chan_pin[0])
      |-> ##[2:3] channel_event_flag[0])
      else $error("capture flag missed");
   a_flag_clear: assert property ($fell(overflow_flag)
      |-> $past(ovf_wr_zero, 2))
      else $error("flag cleared without write");
   a_irq_level: assert property (overflow_irq_ff ==
      (overflow_flag && $past(overflow_irq_enable)))
      else $error("request differs from flag");
endmodule // tefl_chk
bind tefl_top tefl_chk u_chk (.*);
`default_nettype wire

/* File: test/test_tefl_top.sv */
// Self-checking bench for the timer counter and event flags.
`timescale 1ns/10ps
`default_nettype none
module test_tefl_top;
   logic clk = 0, rst = 1, count_en = 0, center_align_select = 0;
   logic overflow_irq_enable = 1, ovf_rd = 0, ovf_wr_zero = 0;
   logic [15:0] modulus = 16'h0000, count_ff;
   logic [3:0] chan_mode = 4'h8, edge_level_select = 4'h0;
   logic [31:0] chan_value = 32'h0003_0000;
   logic [1:0] chan_pin = 2'h0, channel_irq_enable = 2'h3;
   logic [1:0] chan_rd = 2'h0, chan_wr_zero = 2'h0;
   logic [1:0] channel_event_flag, channel_irq_ff;
   logic count_dir_ff, overflow_flag, overflow_irq_ff;
   int mismatches = 0, check_count = 0, cyc = 0;
   tefl_top dut (.*);
   always #5 clk = ~clk;
   // Cut a hang short well after the free run should end.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         wrap_up;
      end
   end
   task chk(string n, logic [15:0] g, logic [15:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task tick(int n);
      repeat (n) @(negedge clk);
   endtask
   task till(logic [15:0] v);
      while (count_ff !== v) tick(1);
   endtask
   // Read step and write-zero step, each a one-cycle pulse.
   task rd(logic o, logic [1:0] c);
      ovf_rd = o;
      chan_rd = c;
      tick(1);
      ovf_rd = 0;
      chan_rd = 2'h0;
   endtask
   task wz(logic o, logic [1:0] c);
      ovf_wr_zero = o;
      chan_wr_zero = c;
      tick(1);
      ovf_wr_zero = 0;
      chan_wr_zero = 2'h0;
      tick(2);
   endtask
   task t_cap;
      for (int s = 0; s < 4; s++) begin
         edge_level_select[1:0] = s[1:0];
         chan_pin[0] = 1;
         tick(4);
         chk("rise", channel_event_flag[0], s[0]);
         rd(0, 2'h1);
         wz(0, 2'h1);
         chan_pin[0] = 0;
         tick(4);
         chk("fall", channel_event_flag[0], s[1]);
         rd(0, 2'h1);
         wz(0, 2'h1);
      end
      $display("capture test done");
   endtask
   task t_free;
      count_en = 1;
      till(16'hffff);
      tick(1);
      chk("count", count_ff, 16'h0000);
      tick(1);
      chk("ovf", overflow_flag, 1);
      chk("irq", overflow_irq_ff, 1);
      $display("free run test done");
   endtask
   // A write with no read first, then an event between the steps.
   task t_clear;
      count_en = 0;
      modulus = 16'h0010;
      wz(1, 2'h0);
      chk("ovf", overflow_flag, 1);
      rd(1, 2'h0);
      count_en = 1;
      tick(20);
      count_en = 0;
      wz(1, 2'h0);
      chk("ovf", overflow_flag, 1);
      rd(1, 2'h0);
      wz(1, 2'h0);
      chk("ovf", overflow_flag, 0);
      chk("irq", overflow_irq_ff, 0);
      $display("clear test done");
   endtask
   task t_updown;
      rd(0, 2'h2);
      wz(0, 2'h2);
      chk("chan", channel_event_flag[1], 0);
      center_align_select = 1;
      modulus = 16'h0008;
      count_en = 1;
      till(16'h0008);
      tick(1);
      chk("dir", count_dir_ff, 1);
      chk("count", count_ff, 16'h0007);
      till(16'h0000);
      tick(1);
      chk("dir", count_dir_ff, 0);
      chk("chan", channel_event_flag[1], 1);
      count_en = 0;
      rd(0, 2'h2);
      wz(0, 2'h2);
      count_en = 1;
      till(16'h0004);
      tick(2);
      chk("chan", channel_event_flag[1], 1);
      chk("chirq", channel_irq_ff[1], 1);
      $display("up/down test done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Reset for eight cycles, then the tests in turn.
   initial begin
      tick(8);
      rst = 0;
      t_cap;
      t_free;
      t_clear;
      t_updown;
      wrap_up;
   end
endmodule // test_tefl_top
`default_nettype wire
